// [can_power_mode_bit_timing_tb_top.sv]
// Testbench for the CAN power mode and bit timing block
`timescale 1ns/1ps
`default_nettype none
module can_power_mode_bit_timing_tb_top;
   import cpb_pkg::*;
   logic         clock, nrst, cpuStop, xtalTick, pllTick, domReq, rxPin, txPin;
   cpb_apb_req_t req;
   cpb_apb_rsp_t rsp;
   cpb_eng_in_t  eng;
   cpb_eng_out_t eo;
   logic [32:0]  expQ[$];
   logic [32:0]  e;
   logic [31:0]  rnd = 32'h52;
   logic [7:0]   rv;
   int           errors, total_checks;

   cpb_power_timing cpb_power_timing_inst (.clock(clock), .nrst(nrst), .apbReq(req),
      .apbRsp(rsp), .cpuStop(cpuStop), .xtalTick(xtalTick), .pllTick(pllTick),
      .canRxPin(rxPin), .engIn(eng), .engOut(eo), .canTxPin(txPin));
   cpb_bus_node cpb_bus_node_inst (.txPin(txPin), .domReq(domReq), .rxPin(rxPin));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   task automatic chk(input string n, input logic [32:0] ex, input logic [32:0] got);
      total_checks++;
      if (got !== ex) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, ex, got);
      end
   endtask

   task automatic complete_run;
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ***********************************************
   // APB master and read monitor
   // ***********************************************
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] ex);
      int n;
      n = 0;
      req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
      if (!w) begin
         expQ.push_back(ex);
      end
      @(posedge clock);
      req.penable <= 1'b1;
      @(posedge clock);
      while (rsp.pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clock);
      end
      if (rsp.pready !== 1'b1) chk("pready", 1, rsp.pready);
      req <= '0;
      @(posedge clock);
   endtask

   always @(posedge clock) begin
      if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
         e = expQ.pop_front();
         chk("read", e, {rsp.pslverr, rsp.prdata});
      end
   end

   always @(posedge clock) begin
      rnd <= xs(rnd);
      pllTick <= rnd[0];
   end

   // Counts selected clock ticks sampled between two bit starts
   task automatic bitlen(input int ex, input logic usePll);
      int n;
      int w;
      n = 0;
      w = 0;
      while (eo.bitStart !== 1'b1 && w < 2000) begin
         w++;
         @(posedge clock);
      end
      do begin
         if ((usePll ? pllTick : xtalTick) === 1'b1) n++;
         w++;
         @(posedge clock);
      end while (eo.bitStart !== 1'b1 && w < 2000);
      if (w >= 2000) chk("bit timeout", 0, 1);
      chk("bit length", ex, n);
   endtask

   // ***********************************************
   // Clock, watchdog and scenarios
   // ***********************************************
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   initial begin
      #200000;
      errors++;
      complete_run();
   end

   initial begin
      nrst = 1'b0;
      cpuStop = 1'b0;
      xtalTick = 1'b1;
      domReq = 1'b0;
      req = '0;
      eng = 5'h01;
      errors = 0;
      total_checks = 0;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      apb(0, OFS_CTRL0, 0, 33'h2);
      apb(0, OFS_TIME1, 0, 33'h13);
      apb(0, OFS_STAT, 0, 33'h4);
      apb(0, 12'h020, 0, 33'h100000000);
      rv = rnd[7:0];
      apb(1, OFS_TIME0, {24'h0, rv}, 0);
      apb(0, OFS_TIME0, 0, {25'h0, rv});
      apb(1, OFS_TIME0, 32'h01, 0);
      apb(1, OFS_CTRL0, 32'h0, 0);
      apb(1, OFS_TIME0, 32'h3f, 0);
      apb(0, OFS_TIME0, 0, 33'h01);
      apb(1, OFS_TIME1, 32'h7f, 0);
      apb(0, OFS_TIME1, 0, 33'h13);
      bitlen(14, 1'b0);
      repeat (150) @(posedge clock);
      chk("protoEn", 1, eo.protoEn);
      apb(0, OFS_STAT, 0, 33'h8);
      apb(1, OFS_CTRL0, 32'h1, 0);
      repeat (2) @(posedge clock);
      chk("sleepAck", 1, eo.sleepAck);
      chk("canTxPin", 1, txPin);
      apb(0, OFS_STAT, 0, 33'h3);
      apb(1, OFS_CTRL0, 32'h0, 0);
      repeat (2) @(posedge clock);
      chk("sleepAck", 0, eo.sleepAck);
      eng <= 5'h15;
      apb(1, OFS_CTRL0, 32'h5, 0);
      repeat (5) @(posedge clock);
      chk("sleepAck", 0, eo.sleepAck);
      eng.txActive <= 1'b0;
      repeat (3) @(posedge clock);
      chk("sleepAck", 0, eo.sleepAck);
      eng.rxActive <= 1'b0;
      repeat (3) @(posedge clock);
      chk("sleepAck", 1, eo.sleepAck);
      domReq <= 1'b1;
      repeat (6) @(posedge clock);
      domReq <= 1'b0;
      chk("sleepAck", 0, eo.sleepAck);
      chk("wakeIrq", 1, eo.wakeIrq);
      apb(1, OFS_STAT, 32'h10, 0);
      chk("wakeIrq", 0, eo.wakeIrq);
      apb(1, OFS_CTRL0, 32'h2, 0);
      repeat (2) @(posedge clock);
      chk("mode", MD_HALT, eo.mode);
      apb(1, OFS_CTRL1, 32'h3, 0);
      apb(0, OFS_CTRL1, 0, 33'h3);
      apb(1, OFS_CTRL0, 32'h8, 0);
      eng.frameValid <= 1'b1;
      @(posedge clock);
      eng.frameValid <= 1'b0;
      repeat (3) @(posedge clock);
      chk("timerCh0", 1, eo.timerCh0);
      bitlen(14, 1'b1);
      apb(1, OFS_CTRL0, 32'h1, 0);
      domReq <= 1'b1;
      repeat (6) @(posedge clock);
      domReq <= 1'b0;
      repeat (4) @(posedge clock);
      chk("sleepAck", 1, eo.sleepAck);
      domReq <= 1'b1;
      repeat (410) @(posedge clock);
      domReq <= 1'b0;
      chk("sleepAck", 0, eo.sleepAck);
      chk("wakeIrq", 0, eo.wakeIrq);
      cpuStop <= 1'b1;
      repeat (3) @(posedge clock);
      chk("mode", MD_PDOWN, eo.mode);
      chk("canTxPin", 1, txPin);
      apb(0, OFS_CTRL0, 0, 33'h100000000);
      complete_run();
   end
endmodule
`default_nettype wire

// [cpb_bus_node.sv]
// CAN bus node model driving the receive pin
`timescale 1ns/1ps
`default_nettype none
module cpb_bus_node (
   input  wire logic txPin,
   input  wire logic domReq,
   output logic      rxPin
);
   // Wired-and bus, recessive high when released
   assign rxPin = txPin & ~domReq;
endmodule
`default_nettype wire

// [cpb_pkg.sv]
// Constants and types shared by the CAN power mode and bit timing block
`default_nettype none
package cpb_pkg;

   // ***********************************************
   // Register map
   // ***********************************************
   localparam int          ADDR_W     = 12;
   localparam logic [11:0] OFS_CTRL0  = 12'h000;
   localparam logic [11:0] OFS_CTRL1  = 12'h004;
   localparam logic [11:0] OFS_TIME0  = 12'h008;
   localparam logic [11:0] OFS_TIME1  = 12'h00c;
   localparam logic [11:0] OFS_STAT   = 12'h010;

   localparam int CTL0_SLEEP_BIT = 0;
   localparam int CTL0_HALT_BIT  = 1;
   localparam int CTL0_WIE_BIT   = 2;
   localparam int CTL0_LINK_BIT  = 3;
   localparam int CTL1_FILT_BIT  = 0;
   localparam int CTL1_CLK_BIT   = 1;
   localparam int TIM0_PRESC_LSB = 0;
   localparam int TIM0_SJW_LSB   = 6;
   localparam int TIM1_SEG1_LSB  = 0;
   localparam int TIM1_SEG2_LSB  = 4;
   localparam int STAT_ACK_BIT   = 0;
   localparam int STAT_MODE_LSB  = 1;
   localparam int STAT_SYNC_BIT  = 3;
   localparam int STAT_WAKE_BIT  = 4;

   // ***********************************************
   // Reset values and limits
   // ***********************************************
   localparam logic       RST_HALT   = 1'b1;
   localparam logic [5:0] RST_PRESC  = 6'h00;
   localparam logic [1:0] RST_SJW    = 2'h0;
   localparam logic [3:0] RST_SEG1   = 4'h3;
   localparam logic [2:0] RST_SEG2   = 3'h1;
   localparam logic [4:0] SEG1_MIN   = 5'h04;
   localparam logic [4:0] SEG2_MIN   = 5'h02;
   localparam logic [3:0] RESYNC_BITS = 4'hb;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_MHZ       = 200;
   localparam int WAKE_FILT_NS  = 2000;
   localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT_W        = $clog2(WAKE_FILT_CYC + 1);

   // ***********************************************
   // Types
   // ***********************************************
   typedef enum logic [1:0] {
      MD_NORMAL = 2'b00, MD_SLEEP = 2'b01, MD_HALT = 2'b10, MD_PDOWN = 2'b11
   } cpb_mode_t;

   typedef enum logic [1:0] {
      SL_AWAKE = 2'b00, SL_DRAIN = 2'b01, SL_ASLEEP = 2'b10
   } cpb_sleep_t;

   typedef enum logic [1:0] {
      PH_SYNC = 2'b00, PH_SEG1 = 2'b01, PH_SEG2 = 2'b10
   } cpb_phase_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } cpb_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } cpb_apb_rsp_t;

   typedef struct packed {
      logic txActive;
      logic txPending;
      logic rxActive;
      logic frameValid;
      logic txBit;
   } cpb_eng_in_t;

   typedef struct packed {
      logic      protoEn;
      logic      tqTick;
      logic      samplePulse;
      logic      rxSample;
      logic      bitStart;
      logic      deferOk;
      logic      wakeRelease;
      logic      framePulse;
      logic      timerCh0;
      logic      wakeIrq;
      logic      sleepAck;
      cpb_mode_t mode;
   } cpb_eng_out_t;

endpackage
`default_nettype wire

// [cpb_power_timing.sv]
// CAN controller low power modes, timer link and bit timing generation
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Sleep request while transmitting waits until no queued message remains
// - Sleep request while receiving waits for the frame to finish
// - Sleep request when idle enters sleep at once
// - Sleep acknowledge stays set for the whole time asleep
// - Protocol clocks stop in sleep; bus-off recovery count clears meanwhile
// - Transmit pin stays recessive while asleep
// - No buffer copy or abort while asleep; register access still works
// - Wake on bus activity, sleep request cleared, or soft halt set
// - After wake, wait eleven recessive bits before joining the bus
// - On wake, release deferred copy, aborts and transmissions
// - Soft halt stops activity at once; registers remain accessible
// - CPU stop forces power down: halt, tx recessive, no register access
// - Outside stop, mode follows acknowledge and soft halt bits
// - Wake interrupt only when acknowledge and wake enable are both one
// - CPU wait leaves the controller fully active
// - Optional low-pass filter on receive line for wake in sleep
// - One bit time pulse after every valid frame end
// - Timer link enable routes that pulse to capture channel zero
// - Clock select picks crystal or PLL as controller clock
// - Prescaler divides controller clock into time quanta
// - Bit is sync quantum, segment one 4..16, segment two 2..8
// - Resync jump width is 1 to 4 quanta
// - Config and timing writes blocked unless soft halt is set
module cpb_power_timing (
   input  wire logic                  clock,
   input  wire logic                  nrst,
   input  wire cpb_pkg::cpb_apb_req_t apbReq,
   output var  cpb_pkg::cpb_apb_rsp_t apbRsp,
   input  wire logic                  cpuStop,
   input  wire logic                  xtalTick,
   input  wire logic                  pllTick,
   input  wire logic                  canRxPin,
   input  wire cpb_pkg::cpb_eng_in_t  engIn,
   output var  cpb_pkg::cpb_eng_out_t engOut,
   output logic                       canTxPin
);
   import cpb_pkg::*;

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic             slpReq;
      logic             halt;
      logic             wakeIe;
      logic             linkEn;
      logic             filtSel;
      logic             clkSel;
      logic [5:0]       presc;
      logic [1:0]       resync_jump_width;
      logic [3:0]       seg1;
      logic [2:0]       seg2;
      cpb_sleep_t       sleepSt;
      logic             wakeFlag;
      logic             syncDone;
      logic [3:0]       recCnt;
      logic             rxMeta;
      logic             rxSync;
      logic             rxPrev;
      logic             edgePend;
      logic [FILT_W-1:0] filtCnt;
      logic [5:0]       tqCnt;
      cpb_phase_t       phase;
      logic [4:0]       segCnt;
      logic [4:0]       ext;
      logic             txPin;
      cpb_eng_out_t     out;
      cpb_apb_rsp_t     rsp;
   } cpb_state_t;

   cpb_state_t st_reg;
   cpb_state_t st_next;

   cpb_mode_t  modeNow;
   logic       busy;
   logic       run;
   logic       dominant;
   logic       wakeBus;
   logic       clkTick;
   logic       setup;
   logic       access;
   logic       addrOk;
   logic [4:0] len1;
   logic [4:0] len2;
   logic [4:0] sjwLen;
   logic [4:0] extNew;

   function automatic logic [4:0] seg1Len(input logic [3:0] c);
      logic [4:0] v;
      v = {1'b0, c} + 5'h01;
      return (v < SEG1_MIN) ? SEG1_MIN : v;
   endfunction

   function automatic logic [4:0] seg2Len(input logic [2:0] c);
      logic [4:0] v;
      v = {2'b00, c} + 5'h01;
      return (v < SEG2_MIN) ? SEG2_MIN : v;
   endfunction

   function automatic logic [31:0] regRead(input logic [11:0] a, input cpb_state_t s);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         OFS_CTRL0: begin
            d[CTL0_SLEEP_BIT] = s.slpReq;
            d[CTL0_HALT_BIT]  = s.halt;
            d[CTL0_WIE_BIT]   = s.wakeIe;
            d[CTL0_LINK_BIT]  = s.linkEn;
         end
         OFS_CTRL1: begin
            d[CTL1_FILT_BIT] = s.filtSel;
            d[CTL1_CLK_BIT]  = s.clkSel;
         end
         OFS_TIME0: begin
            d[TIM0_PRESC_LSB +: 6] = s.presc;
            d[TIM0_SJW_LSB +: 2]   = s.resync_jump_width;
         end
         OFS_TIME1: begin
            d[TIM1_SEG1_LSB +: 4] = s.seg1;
            d[TIM1_SEG2_LSB +: 3] = s.seg2;
         end
         OFS_STAT: begin
            d[STAT_ACK_BIT]      = s.out.sleepAck;
            d[STAT_MODE_LSB +: 2] = s.out.mode;
            d[STAT_SYNC_BIT]     = s.syncDone;
            d[STAT_WAKE_BIT]     = s.wakeFlag;
         end
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      st_next = st_reg;
      st_next.out.tqTick      = 1'b0;
      st_next.out.samplePulse = 1'b0;
      st_next.out.bitStart    = 1'b0;
      st_next.out.wakeRelease = 1'b0;
      st_next.rsp.pready      = 1'b0;
      st_next.rsp.pslverr     = 1'b0;
      st_next.rxMeta          = canRxPin;
      st_next.rxSync          = st_reg.rxMeta;
      st_next.rxPrev          = st_reg.rxSync;

      // Mode decode; CPU wait is not an input and changes nothing
      if (cpuStop)                  modeNow = MD_PDOWN;
      else if (st_reg.halt)         modeNow = MD_HALT;
      else if (st_reg.out.sleepAck) modeNow = MD_SLEEP;
      else                          modeNow = MD_NORMAL;
      busy     = engIn.txActive | engIn.txPending | engIn.rxActive;
      run      = (modeNow == MD_NORMAL);
      dominant = ~st_reg.rxSync;
      clkTick  = st_reg.clkSel ? pllTick : xtalTick;
      len1     = seg1Len(st_reg.seg1);
      len2     = seg2Len(st_reg.seg2);
      sjwLen   = {3'b000, st_reg.resync_jump_width} + 5'h01;
      extNew   = st_reg.ext;
      wakeBus  = 1'b0;
      setup    = apbReq.psel & ~apbReq.penable;
      access   = apbReq.psel & apbReq.penable & st_reg.rsp.pready;
      addrOk   = (apbReq.paddr == OFS_CTRL0) || (apbReq.paddr == OFS_CTRL1) ||
                 (apbReq.paddr == OFS_TIME0) || (apbReq.paddr == OFS_TIME1) ||
                 (apbReq.paddr == OFS_STAT);

      // Register access
      if (setup) begin
         st_next.rsp.pready  = 1'b1;
         st_next.rsp.pslverr = (modeNow == MD_PDOWN) || !addrOk;
         st_next.rsp.prdata  = (modeNow == MD_PDOWN) ? 32'h0000_0000 :
                               regRead(apbReq.paddr, st_reg);
      end
      if (access && apbReq.pwrite && !st_reg.rsp.pslverr) begin
         case (apbReq.paddr)
            OFS_CTRL0: begin
               st_next.slpReq = apbReq.pwdata[CTL0_SLEEP_BIT];
               st_next.halt   = apbReq.pwdata[CTL0_HALT_BIT];
               st_next.wakeIe = apbReq.pwdata[CTL0_WIE_BIT];
               st_next.linkEn = apbReq.pwdata[CTL0_LINK_BIT];
            end
            OFS_CTRL1: begin
               if (st_reg.halt) begin
                  st_next.filtSel = apbReq.pwdata[CTL1_FILT_BIT];
                  st_next.clkSel  = apbReq.pwdata[CTL1_CLK_BIT];
               end
            end
            OFS_TIME0: begin
               if (st_reg.halt) begin
                  st_next.presc = apbReq.pwdata[TIM0_PRESC_LSB +: 6];
                  st_next.resync_jump_width   = apbReq.pwdata[TIM0_SJW_LSB +: 2];
               end
            end
            OFS_TIME1: begin
               if (st_reg.halt) begin
                  st_next.seg1 = apbReq.pwdata[TIM1_SEG1_LSB +: 4];
                  st_next.seg2 = apbReq.pwdata[TIM1_SEG2_LSB +: 3];
               end
            end
            OFS_STAT: begin
               if (apbReq.pwdata[STAT_WAKE_BIT]) st_next.wakeFlag = 1'b0;
            end
            default: st_next.wakeFlag = st_reg.wakeFlag;
         endcase
      end

      if (modeNow != MD_PDOWN) begin
         // Wake filter on the receive line while asleep
         if (st_reg.sleepSt == SL_ASLEEP && dominant) begin
            if (st_reg.filtCnt != FILT_W'(WAKE_FILT_CYC))
               st_next.filtCnt = st_reg.filtCnt + FILT_W'(1);
         end else begin
            st_next.filtCnt = '0;
         end
         wakeBus = dominant && (!st_reg.filtSel ||
                   st_reg.filtCnt == FILT_W'(WAKE_FILT_CYC - 1));

         // Sleep handshake
         case (st_reg.sleepSt)
            SL_AWAKE: begin
               if (st_reg.slpReq && !st_reg.halt) begin
                  if (busy) begin
                     st_next.sleepSt = SL_DRAIN;
                  end else begin
                     st_next.sleepSt      = SL_ASLEEP;
                     st_next.out.sleepAck = 1'b1;
                  end
               end
            end
            SL_DRAIN: begin
               if (!st_reg.slpReq || st_reg.halt) begin
                  st_next.sleepSt = SL_AWAKE;
               end else if (!busy) begin
                  st_next.sleepSt      = SL_ASLEEP;
                  st_next.out.sleepAck = 1'b1;
               end
            end
            SL_ASLEEP: begin
               if (wakeBus || !st_reg.slpReq || st_reg.halt) begin
                  st_next.sleepSt         = SL_AWAKE;
                  st_next.out.sleepAck    = 1'b0;
                  st_next.out.wakeRelease = 1'b1;
                  if (wakeBus) st_next.slpReq = 1'b0;
                  if (wakeBus && st_reg.wakeIe) st_next.wakeFlag = 1'b1;
               end
            end
            default: st_next.sleepSt = SL_AWAKE;
         endcase
      end

      // Time quantum prescaler and segment sequencer
      if (run) begin
         if (st_reg.rxPrev && dominant && st_reg.phase != PH_SYNC)
            st_next.edgePend = 1'b1;
         if (clkTick) begin
            if (st_reg.tqCnt == st_reg.presc) begin
               st_next.tqCnt      = 6'h00;
               st_next.out.tqTick = 1'b1;
            end else begin
               st_next.tqCnt = st_reg.tqCnt + 6'h01;
            end
         end
         if (st_next.out.tqTick) begin
            st_next.edgePend = 1'b0;
            case (st_reg.phase)
               PH_SYNC: begin
                  st_next.phase  = PH_SEG1;
                  st_next.segCnt = 5'h01;
               end
               PH_SEG1: begin
                  if (st_reg.edgePend && st_reg.ext == 5'h00)
                     extNew = (st_reg.segCnt < sjwLen) ? st_reg.segCnt : sjwLen;
                  st_next.ext = extNew;
                  if (st_reg.segCnt >= len1 + extNew) begin
                     st_next.phase           = PH_SEG2;
                     st_next.segCnt          = 5'h01;
                     st_next.out.samplePulse = 1'b1;
                     st_next.out.rxSample    = st_reg.rxSync;
                  end else begin
                     st_next.segCnt = st_reg.segCnt + 5'h01;
                  end
               end
               PH_SEG2: begin
                  if (st_reg.segCnt >= len2 ||
                      (st_reg.edgePend && (len2 - st_reg.segCnt) <= sjwLen)) begin
                     st_next.phase        = PH_SYNC;
                     st_next.ext          = 5'h00;
                     st_next.out.bitStart = 1'b1;
                  end else begin
                     st_next.segCnt = st_reg.segCnt + 5'h01;
                  end
               end
               default: st_next.phase = PH_SYNC;
            endcase
         end
         // Eleven recessive bits before joining the bus
         if (st_next.out.samplePulse && !st_reg.syncDone) begin
            if (!st_reg.rxSync) begin
               st_next.recCnt = 4'h0;
            end else if (st_reg.recCnt == RESYNC_BITS - 4'h1) begin
               st_next.syncDone = 1'b1;
            end else begin
               st_next.recCnt = st_reg.recCnt + 4'h1;
            end
         end
      end else begin
         // Protocol clocks stopped; halt or power down cut the bit at once
         st_next.tqCnt    = 6'h00;
         st_next.phase    = PH_SYNC;
         st_next.segCnt   = 5'h00;
         st_next.ext      = 5'h00;
         st_next.edgePend = 1'b0;
         st_next.syncDone = 1'b0;
         st_next.recCnt   = 4'h0;
      end

      // Transmit pin: launch at sync start, recessive unless fully on line
      if (!run || !st_reg.syncDone) st_next.txPin = 1'b1;
      else if (st_next.out.bitStart) st_next.txPin = engIn.txBit;

      // Valid-frame pulse for one bit time
      if (!run) st_next.out.framePulse = 1'b0;
      else if (st_reg.out.framePulse && st_next.out.bitStart) st_next.out.framePulse = 1'b0;
      if (run && engIn.frameValid) st_next.out.framePulse = 1'b1;
      st_next.out.timerCh0 = st_reg.out.framePulse & st_reg.linkEn;

      st_next.out.protoEn = run & st_next.syncDone;
      st_next.out.deferOk = run;
      st_next.out.mode    = modeNow;
      st_next.out.wakeIrq = st_next.wakeFlag & st_reg.wakeIe;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_reg        <= '0;
         st_reg.halt   <= RST_HALT;
         st_reg.presc  <= RST_PRESC;
         st_reg.resync_jump_width    <= RST_SJW;
         st_reg.seg1   <= RST_SEG1;
         st_reg.seg2   <= RST_SEG2;
         st_reg.rxMeta <= 1'b1;
         st_reg.rxSync <= 1'b1;
         st_reg.rxPrev <= 1'b1;
         st_reg.txPin  <= 1'b1;
         st_reg.out.mode <= MD_HALT;
      end else begin
         st_reg <= st_next;
      end
   end

   assign apbRsp   = st_reg.rsp;
   assign engOut   = st_reg.out;
   assign canTxPin = st_reg.txPin;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   property p_tx_recessive;
      (modeNow != MD_NORMAL) |=> canTxPin;
   endproperty
   a_tx_recessive: assert property (p_tx_recessive) else $error("tx not recessive");

   property p_idle_sleep;
      (st_reg.sleepSt == SL_AWAKE && st_reg.slpReq && !st_reg.halt && !busy &&
       modeNow != MD_PDOWN) |=> engOut.sleepAck;
   endproperty
   a_idle_sleep: assert property (p_idle_sleep) else $error("idle sleep late");

   property p_drain_hold;
      (st_reg.sleepSt == SL_DRAIN && busy && st_reg.slpReq && !st_reg.halt)
         |=> !engOut.sleepAck;
   endproperty
   a_drain_hold: assert property (p_drain_hold) else $error("slept while busy");

   sequence s_wake_cause;
      engOut.sleepAck && modeNow != MD_PDOWN && (!st_reg.slpReq || st_reg.halt);
   endsequence
   sequence s_woken;
      !engOut.sleepAck && engOut.wakeRelease;
   endsequence
   property p_wake;
      s_wake_cause |=> s_woken ##1 !engOut.wakeRelease;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");

   property p_cfg_lock;
      (access && apbReq.pwrite && !st_reg.halt && apbReq.paddr == OFS_TIME1)
         |=> $stable(st_reg.seg1) && $stable(st_reg.seg2);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("timing written");

   property p_pdown_refuse;
      (setup && cpuStop) |=> apbRsp.pready && apbRsp.pslverr;
   endproperty
   a_pdown_refuse: assert property (p_pdown_refuse) else $error("access in stop");

   property p_frame_pulse;
      $rose(engOut.framePulse) |-> $past(engIn.frameValid);
   endproperty
   a_frame_pulse: assert property (p_frame_pulse) else $error("stray pulse");

   property p_timer_link;
      engOut.timerCh0 |-> $past(engOut.framePulse) && $past(st_reg.linkEn);
   endproperty
   a_timer_link: assert property (p_timer_link) else $error("link wrong");

   property p_seg1_min;
      engOut.samplePulse |-> $past(st_reg.segCnt) >= SEG1_MIN;
   endproperty
   a_seg1_min: assert property (p_seg1_min) else $error("seg one short");

   property p_sjw_limit;
      st_reg.ext <= sjwLen;
   endproperty
   a_sjw_limit: assert property (p_sjw_limit) else $error("jump too wide");

   property p_resync;
      $rose(engOut.protoEn) |-> $past(st_reg.recCnt) == RESYNC_BITS - 4'h1;
   endproperty
   a_resync: assert property (p_resync) else $error("joined early");

   property p_wake_irq;
      $rose(st_reg.wakeFlag) |-> $past(engOut.sleepAck) && $past(st_reg.wakeIe);
   endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("bad wake irq");

endmodule
`default_nettype wire
